// ### pkg/rhfb_regs.vh
// Constants for the reset hold and flash boot sequencer.
// Assumes a 50 MHz core clock; included by bare name from logic files.
`ifndef RHFB_REGS_VH
`define RHFB_REGS_VH

// ============================================================
// Clock and timing
`define RHFB_CLK_MHZ          50
`define RHFB_HOLD_WINDOW_US   500
`define RHFB_HOLD_WINDOW_CYC  16'h61A8  // 500 us at 50 MHz, sized to the hold counter
`define RHFB_SCK_HALF_CYC     5'h01
`define RHFB_DONE_PULSE_CYC   8'h10

// ============================================================
// Serial flash boot read
`define RHFB_CMD_READ         8'h03
`define RHFB_BOOT_ADDR        24'h000000
`define RHFB_BOOT_WORDS       8'h10
`define RHFB_SHIFT_W          32

`endif

// ### logic/rhfb_flash_shifter.v
// Serial flash word shifter: mode 0, master clock, one frame per start.
// Assumes start is only raised while idle; all inputs but the asynchronous reset are synchronous.
`include "rhfb_regs.vh"

module rhfb_flash_shifter (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        start_in,
  input  wire [5:0]  nbits_in,
  input  wire [31:0] tx_in,
  input  wire        miso_in,
  output reg         sck_out,
  output reg         mosi_out,
  output reg         cs_n_out,
  output reg         busy_out,
  output reg         done_out,
  output reg  [31:0] rx_out
);
  reg [31:0] tx_reg;
  reg [5:0]  cnt_reg;
  reg [4:0]  div_reg;

  // ============================================================
  // Frame engine; data changes on falling SCK, sampled on rising
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_out  <= 1'b0;
      mosi_out <= 1'b0;
      cs_n_out <= 1'b1;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rx_out   <= 32'h00000000;
      tx_reg   <= 32'h00000000;
      cnt_reg  <= 6'h00;
      div_reg  <= 5'h00;
    end else begin
      done_out <= 1'b0;
      if (!busy_out) begin
        cs_n_out <= 1'b1;                      // Deselected between frames
        if (start_in) begin
          busy_out <= 1'b1;
          cs_n_out <= 1'b0;                    // Select flash
          tx_reg   <= tx_in << 1;
          mosi_out <= tx_in[31];               // Command/address first bit
          cnt_reg  <= nbits_in;
          div_reg  <= 5'h00;
        end
      end else if (div_reg != `RHFB_SCK_HALF_CYC) begin
        div_reg <= div_reg + 5'h01;
      end else begin
        div_reg <= 5'h00;
        if (!sck_out) begin
          sck_out <= 1'b1;                     // Master generates clock
          rx_out  <= {rx_out[30:0], miso_in};  // Input timed by our clock
        end else begin
          sck_out <= 1'b0;
          if (cnt_reg == 6'h01) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            cs_n_out <= 1'b1;                  // Release select at frame end
          end else begin
            cnt_reg  <= cnt_reg - 6'h01;
            mosi_out <= tx_reg[31];            // Output timed by our clock
            tx_reg   <= tx_reg << 1;
          end
        end
      end
    end
  end
endmodule // rhfb_flash_shifter

// ### logic/rhfb_sequencer.v
// Start-up sequencer: reset release, flash boot read, mirror hold, done flag.
// Assumes RST_N_IN is the power-on reset; output enables are active low.
`include "rhfb_regs.vh"

module rhfb_sequencer (
  input  wire        MCLK_IN,
  input  wire        RST_N_IN,
  input  wire        MIRROR_HOLD_N_IN,
  input  wire        FLASH_SERIAL_IN_IN,
  input  wire        ERROR_EVENT_IN,
  output reg         MIRROR_SUPPLY_ENABLE_OUT,
  output reg         MIRROR_SUPPLY_ENABLE_OE_N_OUT,
  output reg         LAMP_DRIVER_ON_OUT,
  output reg         LAMP_DRIVER_ON_OE_N_OUT,
  output reg  [1:0]  LAMP_SELECT_OUT,
  output reg  [1:0]  LAMP_SELECT_OE_N_OUT,
  output reg         FLASH_SERIAL_CLOCK_OUT,
  output reg         FLASH_SERIAL_OUT_OUT,
  output reg         FLASH_SELECT_N_OUT,
  output reg         FLASH_PINS_OE_N_OUT,
  output reg         INIT_DONE_OUT,
  output reg         MIRRORS_HELD_OUT,
  output reg         BOOT_ERROR_OUT
);
  localparam [4:0] ST_WAIT = 5'h01;
  localparam [4:0] ST_SEND = 5'h02;
  localparam [4:0] ST_READ = 5'h04;
  localparam [4:0] ST_DONE = 5'h08;
  localparam [4:0] ST_RUN  = 5'h10;
  localparam [15:0] HOLD_CYC = `RHFB_HOLD_WINDOW_CYC;

  reg [4:0]  state_reg;
  reg [1:0]  hold_sync_reg;
  reg [1:0]  miso_sync_reg;
  reg [1:0]  err_sync_reg;
  reg        err_seen_reg;
  reg        release_reg;
  reg [7:0]  words_reg;
  reg [7:0]  pulse_reg;
  reg [15:0] hold_cnt_reg;
  reg        start_reg;
  reg [5:0]  nbits_reg;
  reg [31:0] tx_reg;
  reg [31:0] cksum_reg;
  wire       sck;
  wire       mosi;
  wire       cs_n;
  wire       busy;
  wire       done;
  wire [31:0] rx;
  wire       err_rise;

  // ============================================================
  // Pin synchronisers: first stage feeds only the second
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      hold_sync_reg <= 2'h0;
      miso_sync_reg <= 2'h0;
      err_sync_reg  <= 2'h0;
      err_seen_reg  <= 1'b0;
    end else begin
      hold_sync_reg <= {hold_sync_reg[0], MIRROR_HOLD_N_IN};
      miso_sync_reg <= {miso_sync_reg[0], FLASH_SERIAL_IN_IN};
      err_sync_reg  <= {err_sync_reg[0], ERROR_EVENT_IN};
      err_seen_reg  <= err_sync_reg[1];
    end
  end

  assign err_rise = err_sync_reg[1] & ~err_seen_reg;

  // Synchroniser delay adds two cycles to flash input timing; SCK is too fast, so each sample takes the bit before
  rhfb_flash_shifter u_shift (
    .clk_in   (MCLK_IN),
    .rst_n_in (RST_N_IN),
    .start_in (start_reg),
    .nbits_in (nbits_reg),
    .tx_in    (tx_reg),
    .miso_in  (miso_sync_reg[1]),
    .sck_out  (sck),
    .mosi_out (mosi),
    .cs_n_out (cs_n),
    .busy_out (busy),
    .done_out (done),
    .rx_out   (rx)
  );

  // ============================================================
  // Boot sequence; reset release is the rising edge that starts it
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg   <= ST_WAIT;
      release_reg <= 1'b0;
      start_reg   <= 1'b0;
      nbits_reg   <= 6'h00;
      tx_reg      <= 32'h00000000;
      words_reg   <= 8'h00;
      pulse_reg   <= 8'h00;
      cksum_reg   <= 32'h00000000;
      INIT_DONE_OUT  <= 1'b0;
      BOOT_ERROR_OUT <= 1'b0;
    end else begin
      start_reg   <= 1'b0;
      release_reg <= 1'b1;
      if (pulse_reg != 8'h00) begin
        pulse_reg <= pulse_reg - 8'h01;
      end
      INIT_DONE_OUT <= (pulse_reg != 8'h00);
      case (state_reg)
        ST_WAIT: begin
          if (release_reg) begin               // First cycle after release
            start_reg <= 1'b1;
            nbits_reg <= 6'h20;
            tx_reg    <= {`RHFB_CMD_READ, `RHFB_BOOT_ADDR};
            state_reg <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (done) begin
            start_reg <= 1'b1;
            nbits_reg <= 6'h20;
            tx_reg    <= 32'h00000000;
            words_reg <= `RHFB_BOOT_WORDS;
            state_reg <= ST_READ;
          end
        end
        ST_READ: begin
          if (done) begin
            cksum_reg <= cksum_reg ^ rx;
            words_reg <= words_reg - 8'h01;
            if (words_reg == 8'h01) begin
              state_reg <= ST_DONE;
            end else begin
              start_reg <= 1'b1;
            end
          end
        end
        ST_DONE: begin
          pulse_reg <= `RHFB_DONE_PULSE_CYC;   // High then low marks init done
          state_reg <= ST_RUN;
        end
        ST_RUN: begin
          if (err_rise) begin
            pulse_reg      <= `RHFB_DONE_PULSE_CYC;  // Error interrupt pulse
            BOOT_ERROR_OUT <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_WAIT;
        end
      endcase
    end
  end

  // ============================================================
  // Output pins: enabled pins high impedance during reset, driven after; mirrors-held flag driven high in reset
  always @(posedge MCLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      MIRROR_SUPPLY_ENABLE_OUT      <= 1'b0;
      MIRROR_SUPPLY_ENABLE_OE_N_OUT <= 1'b1;
      LAMP_DRIVER_ON_OUT            <= 1'b0;
      LAMP_DRIVER_ON_OE_N_OUT       <= 1'b1;
      LAMP_SELECT_OUT               <= 2'h0;
      LAMP_SELECT_OE_N_OUT          <= 2'h3;
      FLASH_SERIAL_CLOCK_OUT        <= 1'b0;
      FLASH_SERIAL_OUT_OUT          <= 1'b0;
      FLASH_SELECT_N_OUT            <= 1'b1;
      FLASH_PINS_OE_N_OUT           <= 1'b1;
      MIRRORS_HELD_OUT              <= 1'b1;
      hold_cnt_reg                  <= 16'h0000;
    end else begin
      MIRROR_SUPPLY_ENABLE_OE_N_OUT <= 1'b0;
      LAMP_DRIVER_ON_OE_N_OUT       <= 1'b0;
      LAMP_SELECT_OE_N_OUT          <= 2'h0;
      FLASH_PINS_OE_N_OUT           <= 1'b0;
      FLASH_SERIAL_CLOCK_OUT        <= sck;
      FLASH_SERIAL_OUT_OUT          <= mosi;
      FLASH_SELECT_N_OUT            <= cs_n;
      // Low hold level parks mirrors; supply dropped only once hold window ran
      MIRRORS_HELD_OUT <= ~hold_sync_reg[1];
      if (hold_sync_reg[1]) begin
        hold_cnt_reg <= 16'h0000;
      end else if (hold_cnt_reg != HOLD_CYC) begin
        hold_cnt_reg <= hold_cnt_reg + 16'h0001;
      end
      // Supply stays on through the host's 500 us parking window
      MIRROR_SUPPLY_ENABLE_OUT <= (state_reg == ST_RUN) &&
                                  (hold_sync_reg[1] || hold_cnt_reg != HOLD_CYC);
      LAMP_DRIVER_ON_OUT <= (state_reg == ST_RUN) && hold_sync_reg[1];
      LAMP_SELECT_OUT    <= 2'h0;
    end
  end
endmodule // rhfb_sequencer

// ### tb/rhfb_sequencer_assertions.sv
// Checker for the sequencer's flash pins, done flag and hold path.
// Assumes a bind to rhfb_sequencer; sees its ports only.
module rhfb_seq_chk (
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic MIRROR_HOLD_N_IN,
  input wire logic FLASH_SERIAL_CLOCK_OUT,
  input wire logic FLASH_SERIAL_OUT_OUT,
  input wire logic FLASH_SELECT_N_OUT,
  input wire logic FLASH_PINS_OE_N_OUT,
  input wire logic INIT_DONE_OUT,
  input wire logic MIRRORS_HELD_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Properties; reset masks them, so the bench checks the tristate phase
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RST_N_IN);
  property p_boot; $rose(RST_N_IN) |-> ##[1:6] !FLASH_SELECT_N_OUT; endproperty
  a_boot: assert property (p_boot) else $error("boot frame late");
  property p_drive; $rose(RST_N_IN) |-> ##[1:2] !FLASH_PINS_OE_N_OUT; endproperty
  a_drive: assert property (p_drive) else $error("flash pins not driven");
  property p_hlow; !MIRROR_HOLD_N_IN |-> ##[1:3] MIRRORS_HELD_OUT; endproperty
  a_hlow: assert property (p_hlow) else $error("hold not seen");
  property p_hhigh; MIRROR_HOLD_N_IN [*4] |=> !MIRRORS_HELD_OUT; endproperty
  a_hhigh: assert property (p_hhigh) else $error("hold not released");
  property p_sckcs; FLASH_SERIAL_CLOCK_OUT |-> !FLASH_SELECT_N_OUT; endproperty
  a_sckcs: assert property (p_sckcs) else $error("clock outside frame");
  property p_sckhi;
    $rose(FLASH_SERIAL_CLOCK_OUT) |=> FLASH_SERIAL_CLOCK_OUT ##1 !FLASH_SERIAL_CLOCK_OUT;
  endproperty
  a_sckhi: assert property (p_sckhi) else $error("clock high time");
  property p_gap; $rose(FLASH_SELECT_N_OUT) |=> FLASH_SELECT_N_OUT; endproperty
  a_gap: assert property (p_gap) else $error("select gap short");
  property p_dout;
    FLASH_SERIAL_CLOCK_OUT && $past(FLASH_SERIAL_CLOCK_OUT) |-> $stable(FLASH_SERIAL_OUT_OUT);
  endproperty
  a_dout: assert property (p_dout) else $error("data moved while clock high");
  property p_done;
    $rose(INIT_DONE_OUT) |-> INIT_DONE_OUT [*8] ##1 INIT_DONE_OUT [*8] ##1 !INIT_DONE_OUT;
  endproperty
  a_done: assert property (p_done) else $error("done pulse length");
endmodule // rhfb_seq_chk

// ### tb/rhfb_flash_model.sv
// Serial flash stand-in: records the first word, counts frames.
// Assumes mode 0 pins; data line has no pull, so it shows the inverse bit when idle.
module rhfb_flash_model (
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  output wire logic        miso_out,
  output logic      [31:0] cmd_out,
  output int               frames_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] sh_reg    = 32'h0;
  logic [5:0]  bit_cnt   = 6'h00;
  logic        drv_reg   = 1'b0;
  int          frame_cnt = 0;
  // ==========================================
  // Sample on rising clock, MSB first
  // Frame ends on select rise; the empty start-up edge is not counted
  always @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      if (bit_cnt != 6'h00) frame_cnt <= frame_cnt + 1;
      bit_cnt <= 6'h00;
    end else begin
      sh_reg <= {sh_reg[30:0], mosi_in};
      bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt == 6'h1F && frame_cnt == 0) cmd_out <= {sh_reg[30:0], mosi_in};
    end
  end
  // Data changes on falling clock; a changing pattern, not a real image
  always @(negedge sck_in) drv_reg <= bit_cnt[0] ^ bit_cnt[3];
  assign frames_out = frame_cnt;
  assign miso_out = cs_n_in ? ~drv_reg : drv_reg; // Released line: inverse
endmodule // rhfb_flash_model

// ### tb/test_rhfb_sequencer.sv
// Bench for the start-up sequencer: reset, boot read, errors, hold.
// Assumes the flash model on the far side; the bench plays the host.
module test_rhfb_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0, rst_n = 1'b0, hold_n = 1'b0, err = 1'b0;
  logic sup, sup_oe_n, lamp, lamp_oe_n, sck, mosi, cs_n, fl_oe_n, done, held, berr, miso;
  logic [1:0] sel, sel_oe_n;
  logic [31:0] m_cmd;
  int m_frames, err_total = 0, check_count = 0;
  always #10 mclk = ~mclk;
  rhfb_sequencer i_dut (.MCLK_IN(mclk), .RST_N_IN(rst_n), .MIRROR_HOLD_N_IN(hold_n),
    .FLASH_SERIAL_IN_IN(miso), .ERROR_EVENT_IN(err), .MIRROR_SUPPLY_ENABLE_OUT(sup),
    .MIRROR_SUPPLY_ENABLE_OE_N_OUT(sup_oe_n), .LAMP_DRIVER_ON_OUT(lamp),
    .LAMP_DRIVER_ON_OE_N_OUT(lamp_oe_n), .LAMP_SELECT_OUT(sel), .LAMP_SELECT_OE_N_OUT(sel_oe_n),
    .FLASH_SERIAL_CLOCK_OUT(sck), .FLASH_SERIAL_OUT_OUT(mosi), .FLASH_SELECT_N_OUT(cs_n),
    .FLASH_PINS_OE_N_OUT(fl_oe_n), .INIT_DONE_OUT(done), .MIRRORS_HELD_OUT(held),
    .BOOT_ERROR_OUT(berr));
  rhfb_flash_model i_flash (.sck_in(sck), .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso),
    .cmd_out(m_cmd), .frames_out(m_frames));
  // ==========================================
  // Shared compare, bounded wait and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watched output by number: 0 done flag, 1 supply enable, 2 flash select
  function automatic logic pick(input int sel);
    return (sel == 0) ? done : ((sel == 1) ? sup : cs_n);
  endfunction
  task automatic wait_val(input int sel, input logic v, input int n);
    for (int i = 0; i < n && pick(sel) !== v; i++) @(negedge mclk);
    check(32'(pick(sel)), 32'(v));
    if (pick(sel) !== v) print_verdict();
  endtask
  // Reset held with the clock running: outputs float, no frame
  task automatic test_reset;
    repeat (2) @(negedge mclk);
    check(32'({sup_oe_n, lamp_oe_n, sel_oe_n, fl_oe_n}), 32'h1F);
    check(32'({cs_n, held, done}), 32'h6);
    check(32'(m_frames), 32'h0);
    $display("test_reset done");
  endtask
  // Boot read; an early error must be ignored
  task automatic test_boot;
    int n;
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
    hold_n = 1'b1; // Well inside the window
    err = 1'b1;
    repeat (4) @(negedge mclk);
    err = 1'b0;
    wait_val(0, 1'b1, 6000);
    for (n = 0; done === 1'b1 && n < 40; n++) @(negedge mclk);
    check(32'(n), 32'h10);
    if (n == 40) print_verdict();
    check(m_cmd, 32'h03000000);
    check(32'(m_frames), 32'h11);
    repeat (4) @(negedge mclk);
    check(32'({fl_oe_n, sup_oe_n, lamp_oe_n, sel_oe_n, berr}), 32'h0);
    check(32'({sup, lamp, sel}), 32'hC);
    $display("test_boot done");
  endtask
  // Error after boot pulses done and sticks
  task automatic test_error;
    err = 1'b1;
    repeat (4) @(negedge mclk);
    err = 1'b0;
    wait_val(0, 1'b1, 20);
    check(32'(berr), 32'h1);
    wait_val(0, 1'b0, 40);
    $display("test_error done");
  endtask
  // Hold low, supply off after the window, then reset in mid-run
  task automatic test_hold;
    hold_n = 1'b0;
    repeat (5) @(negedge mclk);
    check(32'({held, lamp}), 32'h2);
    repeat (24900) @(negedge mclk);
    check(32'(sup), 32'h1);
    wait_val(1, 1'b0, 200);
    rst_n = 1'b0;
    @(negedge mclk);
    check(32'({fl_oe_n, cs_n}), 32'h3);
    rst_n = 1'b1;
    wait_val(2, 1'b0, 10);
    $display("test_hold done");
  endtask
  initial begin
    test_reset();
    test_boot();
    test_error();
    test_hold();
    print_verdict();
  end
endmodule // test_rhfb_sequencer

bind rhfb_sequencer rhfb_seq_chk i_chk (.MCLK_IN, .RST_N_IN, .MIRROR_HOLD_N_IN,
  .FLASH_SERIAL_CLOCK_OUT, .FLASH_SERIAL_OUT_OUT, .FLASH_SELECT_N_OUT,
  .FLASH_PINS_OE_N_OUT, .INIT_DONE_OUT, .MIRRORS_HELD_OUT);
